// ===== hdl/scr_consts.svh
// Constants of the short-circuit retry fault controller.
`ifndef SCR_CONSTS_SVH
`define SCR_CONSTS_SVH
`define SCR_ADDR_CTRL 4'h0
`define SCR_ADDR_STATUS 4'h4
`define SCR_ADDR_MASK 4'h8
`define SCR_ADDR_STATE 4'hC
`define SCR_CTRL_FORCE_OFF 0
`define SCR_EVT_W 5
`define SCR_EVT_RETRY 0
`define SCR_EVT_THERMAL 1
`define SCR_EVT_EN_LOST 2
`define SCR_EVT_OVERVOLT 3
`define SCR_EVT_STARTED 4
`define SCR_MASK_RESET 5'h00
`define SCR_OC_LIMIT 7
`define SCR_EN_LOW_LIMIT 32
`define SCR_CLK_PERIOD_NS 50
`define SCR_RESTART_NS 200
`define SCR_RESTART_CYC ((`SCR_RESTART_NS + `SCR_CLK_PERIOD_NS - 1) / `SCR_CLK_PERIOD_NS)
`define SCR_RESP_OKAY 2'h0
`define SCR_RESP_SLVERR 2'h2
`endif

// ===== hdl/scr_pkg.sv
// Types of the short-circuit retry fault controller.
package scr_pkg;

    typedef enum logic [2:0] {
        ST_HOLD_LOW,
        ST_RETRY_DISCHARGE,
        ST_SOFT_START,
        ST_START_DELAY,
        ST_RUN
    } scr_state_type;

    typedef struct packed {
        logic fb_below_arm;
        logic fb_above_disarm;
        logic ramp_below_reset;
        logic ramp_above_offset;
        logic current_limit;
        logic pwm_cycle;
        logic enable_sync;
        logic thermal_trip;
        logic overvoltage;
    } scr_cmp_type;

    typedef struct packed {
        logic switch_enable;
        logic error_amp_pulldown;
        logic ramp_discharge;
        logic ramp_charge;
        logic ramp_pulldown;
    } scr_drive_type;

endpackage : scr_pkg

// ===== hdl/scr_sync.sv
// Three-stage input synchroniser with agreement filter.
`timescale 1ns/1ns
module scr_sync
#(
    parameter int WIDTH = 9
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] out_q;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end
        else
        begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // A bit changes only once stages two and three agree.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            out_q <= '0;
        end
        else
        begin
            out_q <= (s3_q & ~(s2_q ^ s3_q)) | (out_q & (s2_q ^ s3_q));
        end
    end

    assign sync_out = out_q;

endmodule : scr_sync

// ===== hdl/scr_fault_ctrl.sv
// Short-circuit retry and fault sequencing controller with AXI4-Lite registers.
// Notes on behaviour
// - Feedback below arm threshold arms protection.
// - Feedback above disarm threshold disarms protection.
// - Current-limit cycle increments overcurrent counter.
// - Clean switching cycle decrements overcurrent counter.
// - Count above seven while armed sets latch.
// - Latch set pulls error amp low.
// - Latch set enables ramp discharge sink.
// - Ramp at reset level: clear, then charge.
// - Ramp above offset releases amp, restarts switching.
// - Retry repeats until short gone or disabled.
// - Short removed gives ordinary soft start.
// - Thermal trip pulls nodes low, auto recovery.
// - Heavy overcurrent below disarm drops power good.
// - Enable low over 32 cycles disables.
// - Overvoltage drops power good, stops switching only.
//
// The AXI4-Lite interface to the registers and the placing of the registers were left to the implementer.
`include "scr_consts.svh"
`timescale 1ns/1ns
module scr_fault_ctrl
#(
    parameter int CNT_W = 4,
    parameter int EN_CNT_W = 6
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Comparator and pin inputs
    input wire scr_pkg::scr_cmp_type cmp_in,
    // Power switch and analog node drive
    output scr_pkg::scr_drive_type drive_out,
    // Power good open-drain pin
    input wire logic power_good_output_in,
    output logic power_good_output_out,
    output logic power_good_output_oe,
    // Interrupt
    output logic irq,
    // AXI4-Lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [3:0] awaddr,
    // AXI4-Lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // AXI4-Lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [3:0] araddr,
    // AXI4-Lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp
);

    // ----------
    // Input synchronisation
    // ----------
    scr_pkg::scr_cmp_type cmp;
    logic pgood_pin;
    logic pwm_prev_q;
    logic cycle_end;

    scr_sync #(.WIDTH($bits(scr_pkg::scr_cmp_type) + 1)) u_sync
    (
        .sys_clk(sys_clk),
        .rst(rst),
        .async_in({cmp_in, power_good_output_in}),
        .sync_out({cmp, pgood_pin})
    );

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            pwm_prev_q <= 1'b0;
        end
        else
        begin
            pwm_prev_q <= cmp.pwm_cycle;
        end
    end

    assign cycle_end = cmp.pwm_cycle && !pwm_prev_q;

    // ----------
    // Registers and state
    // ----------
    scr_pkg::scr_state_type state_q;
    scr_pkg::scr_state_type state_d;
    logic armed_q;
    logic latch_q;
    logic oc_seen_q;
    logic oc_last_q;
    logic [CNT_W-1:0] oc_cnt_q;
    logic [EN_CNT_W-1:0] en_cnt_q;
    logic en_lost_q;
    logic [2:0] dly_q;
    logic force_off_q;
    logic [`SCR_EVT_W-1:0] status_q;
    logic [`SCR_EVT_W-1:0] mask_q;
    logic [`SCR_EVT_W-1:0] events;
    logic thermal_prev_q;
    logic ov_prev_q;
    logic en_lost_prev_q;
    logic fault_hold;
    logic latch_set;
    logic latch_clear;
    logic status_rd;

    assign fault_hold = cmp.thermal_trip || en_lost_q || force_off_q;

    // ----------
    // Arming with hysteresis
    // ----------
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            armed_q <= 1'b0;
        end
        else if (cmp.fb_above_disarm)
        begin
            armed_q <= 1'b0;
        end
        else if (cmp.fb_below_arm)
        begin
            armed_q <= 1'b1;
        end
    end

    // ----------
    // Overcurrent up/down counter
    // ----------
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            oc_seen_q <= 1'b0;
            oc_last_q <= 1'b0;
        end
        else if (cycle_end)
        begin
            oc_seen_q <= cmp.current_limit;
            oc_last_q <= oc_seen_q || cmp.current_limit;
        end
        else if (cmp.current_limit)
        begin
            oc_seen_q <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst || !armed_q || latch_clear)
        begin
            oc_cnt_q <= '0;
        end
        else if (cycle_end && state_q == scr_pkg::ST_RUN)
        begin
            if (oc_seen_q || cmp.current_limit)
            begin
                if (oc_cnt_q != {CNT_W{1'b1}})
                begin
                    oc_cnt_q <= oc_cnt_q + 1'b1;
                end
            end
            else if (oc_cnt_q != '0)
            begin
                oc_cnt_q <= oc_cnt_q - 1'b1;
            end
        end
    end

    // ----------
    // Retry latch
    // ----------
    assign latch_set = armed_q && state_q == scr_pkg::ST_RUN
        && oc_cnt_q > CNT_W'(`SCR_OC_LIMIT);
    assign latch_clear = (state_q == scr_pkg::ST_RETRY_DISCHARGE && cmp.ramp_below_reset)
        || fault_hold;

    always_ff @(posedge sys_clk)
    begin
        if (rst || latch_clear)
        begin
            latch_q <= 1'b0;
        end
        else if (latch_set)
        begin
            latch_q <= 1'b1;
        end
    end

    // ----------
    // Enable loss detection
    // ----------
    always_ff @(posedge sys_clk)
    begin
        if (rst || cmp.enable_sync)
        begin
            en_cnt_q <= '0;
            en_lost_q <= 1'b0;
        end
        else if (cycle_end)
        begin
            if (en_cnt_q <= EN_CNT_W'(`SCR_EN_LOW_LIMIT))
            begin
                en_cnt_q <= en_cnt_q + 1'b1;
            end
            en_lost_q <= en_cnt_q >= EN_CNT_W'(`SCR_EN_LOW_LIMIT);
        end
    end

    // ----------
    // Sequencing state machine
    // ----------
    always_comb
    begin
        state_d = state_q;
        if (fault_hold)
        begin
            state_d = scr_pkg::ST_HOLD_LOW;
        end
        else
        begin
            unique case (state_q)
                scr_pkg::ST_HOLD_LOW:
                begin
                    if (cmp.ramp_below_reset)
                    begin
                        state_d = scr_pkg::ST_SOFT_START;
                    end
                end
                scr_pkg::ST_RETRY_DISCHARGE:
                begin
                    if (cmp.ramp_below_reset)
                    begin
                        state_d = scr_pkg::ST_SOFT_START;
                    end
                end
                scr_pkg::ST_SOFT_START:
                begin
                    if (cmp.ramp_above_offset)
                    begin
                        state_d = scr_pkg::ST_START_DELAY;
                    end
                end
                scr_pkg::ST_START_DELAY:
                begin
                    if (dly_q == '0)
                    begin
                        state_d = scr_pkg::ST_RUN;
                    end
                end
                scr_pkg::ST_RUN:
                begin
                    if (latch_q)
                    begin
                        state_d = scr_pkg::ST_RETRY_DISCHARGE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            state_q <= scr_pkg::ST_HOLD_LOW;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst || state_q != scr_pkg::ST_START_DELAY)
        begin
            dly_q <= 3'(`SCR_RESTART_CYC - 1);
        end
        else if (dly_q != '0)
        begin
            dly_q <= dly_q - 1'b1;
        end
    end

    // ----------
    // Output drive
    // ----------
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            drive_out <= '0;
            power_good_output_out <= 1'b0;
            power_good_output_oe <= 1'b1;
        end
        else
        begin
            drive_out.switch_enable <= state_d == scr_pkg::ST_RUN && !latch_q
                && !latch_set && !cmp.overvoltage;
            drive_out.error_amp_pulldown <= state_d != scr_pkg::ST_START_DELAY
                && state_d != scr_pkg::ST_RUN;
            drive_out.ramp_discharge <= state_d == scr_pkg::ST_RETRY_DISCHARGE;
            drive_out.ramp_charge <= state_d == scr_pkg::ST_SOFT_START
                || state_d == scr_pkg::ST_START_DELAY
                || state_d == scr_pkg::ST_RUN;
            drive_out.ramp_pulldown <= state_d == scr_pkg::ST_HOLD_LOW;
            power_good_output_out <= 1'b0;
            power_good_output_oe <= state_d != scr_pkg::ST_RUN || cmp.overvoltage
                || cmp.thermal_trip || en_lost_q
                || (oc_last_q && !cmp.fb_above_disarm);
        end
    end

    // ----------
    // Events and interrupt
    // ----------
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            thermal_prev_q <= 1'b0;
            ov_prev_q <= 1'b0;
            en_lost_prev_q <= 1'b0;
        end
        else
        begin
            thermal_prev_q <= cmp.thermal_trip;
            ov_prev_q <= cmp.overvoltage;
            en_lost_prev_q <= en_lost_q;
        end
    end

    always_comb
    begin
        events = '0;
        events[`SCR_EVT_RETRY] = latch_set && !latch_q;
        events[`SCR_EVT_THERMAL] = cmp.thermal_trip && !thermal_prev_q;
        events[`SCR_EVT_EN_LOST] = en_lost_q && !en_lost_prev_q;
        events[`SCR_EVT_OVERVOLT] = cmp.overvoltage && !ov_prev_q;
        events[`SCR_EVT_STARTED] = state_q == scr_pkg::ST_START_DELAY
            && state_d == scr_pkg::ST_RUN;
    end

    // A new event wins over the clear caused by a status read.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            status_q <= '0;
        end
        else
        begin
            status_q <= (status_rd ? '0 : status_q) | events;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= |(((status_rd ? '0 : status_q) | events) & mask_q);
        end
    end

    // ----------
    // AXI4-Lite write channel
    // ----------
    logic aw_got_q;
    logic w_got_q;
    logic [3:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic wr_do;

    assign wr_do = aw_got_q && w_got_q && !bvalid;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            awready <= 1'b0;
            aw_got_q <= 1'b0;
            awaddr_q <= '0;
        end
        else if (awvalid && awready)
        begin
            awready <= 1'b0;
            aw_got_q <= 1'b1;
            awaddr_q <= awaddr;
        end
        else if (bvalid && bready)
        begin
            aw_got_q <= 1'b0;
        end
        else
        begin
            awready <= !aw_got_q && !bvalid;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            wready <= 1'b0;
            w_got_q <= 1'b0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end
        else if (wvalid && wready)
        begin
            wready <= 1'b0;
            w_got_q <= 1'b1;
            wdata_q <= wdata;
            wstrb_q <= wstrb;
        end
        else if (bvalid && bready)
        begin
            w_got_q <= 1'b0;
        end
        else
        begin
            wready <= !w_got_q && !bvalid;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            bvalid <= 1'b0;
            bresp <= `SCR_RESP_OKAY;
        end
        else if (wr_do)
        begin
            bvalid <= 1'b1;
            bresp <= (awaddr_q == `SCR_ADDR_CTRL || awaddr_q == `SCR_ADDR_MASK)
                ? `SCR_RESP_OKAY : `SCR_RESP_SLVERR;
        end
        else if (bready)
        begin
            bvalid <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            force_off_q <= 1'b0;
            mask_q <= `SCR_MASK_RESET;
        end
        else if (wr_do && wstrb_q[0])
        begin
            if (awaddr_q == `SCR_ADDR_CTRL)
            begin
                force_off_q <= wdata_q[`SCR_CTRL_FORCE_OFF];
            end
            if (awaddr_q == `SCR_ADDR_MASK)
            begin
                mask_q <= wdata_q[`SCR_EVT_W-1:0];
            end
        end
    end

    // ----------
    // AXI4-Lite read channel
    // ----------
    assign status_rd = arvalid && arready && araddr == `SCR_ADDR_STATUS;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= `SCR_RESP_OKAY;
        end
        else if (arvalid && arready)
        begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rresp <= `SCR_RESP_OKAY;
            unique case (araddr)
                `SCR_ADDR_CTRL: rdata <= {31'h0, force_off_q};
                `SCR_ADDR_STATUS: rdata <= {27'h0, status_q};
                `SCR_ADDR_MASK: rdata <= {27'h0, mask_q};
                `SCR_ADDR_STATE: rdata <= {16'h0, pgood_pin, en_lost_q, latch_q, armed_q,
                    oc_cnt_q, 5'h00, state_q};
                default:
                begin
                    rdata <= '0;
                    rresp <= `SCR_RESP_SLVERR;
                end
            endcase
        end
        else if (rvalid)
        begin
            if (rready)
            begin
                rvalid <= 1'b0;
            end
        end
        else
        begin
            arready <= 1'b1;
        end
    end

endmodule : scr_fault_ctrl

// ===== dv/scr_checker.sv
// Assertions on the ports of the fault controller.
`timescale 1ns/1ns
module scr_checker
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Comparators, drive and power good
    input wire scr_pkg::scr_cmp_type cmp_in,
    input wire scr_pkg::scr_drive_type drive_out,
    input wire logic power_good_output_oe,
    // Write response
    input wire logic bvalid,
    input wire logic bready
);
    logic [7:0] en_low_q;
    logic pwm_q;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    // Counts switching cycle ends seen while enable is low.
    always_ff @(posedge sys_clk)
    begin
        pwm_q <= cmp_in.pwm_cycle;
        if (rst || cmp_in.enable_sync)
            en_low_q <= 8'h00;
        else if (cmp_in.pwm_cycle && !pwm_q && en_low_q != 8'hFF)
            en_low_q <= en_low_q + 8'h01;
    end
    property p_ea_low; drive_out.ramp_discharge |-> drive_out.error_amp_pulldown; endproperty
    a_ea_low: assert property (p_ea_low) else $error("Amp not low in retry.");
    property p_sw_off; drive_out.ramp_discharge |-> !drive_out.switch_enable; endproperty
    a_sw_off: assert property (p_sw_off) else $error("Switching in retry.");
    property p_sink_src; !(drive_out.ramp_discharge && drive_out.ramp_charge); endproperty
    a_sink_src: assert property (p_sink_src) else $error("Sink and source both on.");
    property p_ramp_reset; drive_out.ramp_discharge ##0 (cmp_in.ramp_below_reset
        && cmp_in.enable_sync && !cmp_in.thermal_trip) [*6]
        |-> ##[0:3] (drive_out.ramp_charge && !drive_out.ramp_discharge); endproperty
    a_ramp_reset: assert property (p_ramp_reset) else $error("No recharge.");
    property p_restart; $rose(cmp_in.ramp_above_offset) && drive_out.ramp_charge
        && cmp_in.enable_sync && !cmp_in.thermal_trip && !cmp_in.overvoltage
        |-> !drive_out.switch_enable [*4] ##[1:16] drive_out.switch_enable; endproperty
    a_restart: assert property (p_restart) else $error("No restart.");
    property p_thermal; cmp_in.thermal_trip [*8] |-> ##2 (drive_out.ramp_pulldown
        && drive_out.error_amp_pulldown && !drive_out.switch_enable && power_good_output_oe);
    endproperty
    a_thermal: assert property (p_thermal) else $error("Thermal not obeyed.");
    property p_ov; cmp_in.overvoltage [*8] |-> ##2 (!drive_out.switch_enable
        && power_good_output_oe); endproperty
    a_ov: assert property (p_ov) else $error("Overvoltage not obeyed.");
    property p_en_lost; en_low_q >= 8'h24 |-> !drive_out.switch_enable
        && power_good_output_oe; endproperty
    a_en_lost: assert property (p_en_lost) else $error("Enable loss not obeyed.");
    property p_b_done; bvalid && bready |=> !bvalid; endproperty
    a_b_done: assert property (p_b_done) else $error("Write response kept.");
endmodule : scr_checker
bind scr_fault_ctrl scr_checker scr_checker_i (.sys_clk(sys_clk), .rst(rst), .cmp_in(cmp_in),
    .drive_out(drive_out), .power_good_output_oe(power_good_output_oe), .bvalid(bvalid),
    .bready(bready));

// ===== dv/scr_analog_model.sv
// Behavioural comparators, ramp capacitor and switching clock.
`timescale 1ns/1ns
module scr_analog_model
(
    // Clock
    input wire logic sys_clk,
    // Bench controls
    input wire logic fb_ok,
    input wire logic [1:0] oc_mode,
    input wire logic en,
    input wire logic hot,
    input wire logic ov,
    // Block side
    input wire scr_pkg::scr_drive_type drv,
    output scr_pkg::scr_cmp_type cmp
);
    int ramp = 0, ph = 0, pc = 0;
    // Ramp in millivolts: 20 up, 10 down per clock.
    always @(posedge sys_clk)
    begin
        ph <= (ph + 1) % 8;
        pc <= pc + int'(ph == 7);
        if (drv.ramp_pulldown)
            ramp <= 0;
        else if (drv.ramp_discharge)
            ramp <= (ramp > 10) ? ramp - 10 : 0;
        else if (drv.ramp_charge && ramp < 1000)
            ramp <= ramp + 20;
    end
    // Current limit trips only while the switches run.
    assign cmp = '{!fb_ok, fb_ok, ramp < 100, ramp > 200,
        drv.switch_enable && ph inside {[2:5]} && (oc_mode == 2'h1 || (oc_mode == 2'h2 && pc[0])),
        ph < 4, en, hot, ov};
endmodule : scr_analog_model

// ===== dv/scr_fault_ctrl_test.sv
// Self-checking testbench of the fault controller.
`timescale 1ns/1ns
`include "scr_consts.svh"
module scr_fault_ctrl_test;
    localparam scr_pkg::scr_drive_type SW = 5'h10, EA = 5'h08, DIS = 5'h04, CHG = 5'h02;
    localparam scr_pkg::scr_drive_type PD = 5'h01;
    logic sys_clk = 1'b0, rst = 1'b1, fb_ok = 1'b1, en = 1'b1, hot = 1'b0, ov = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [1:0] oc_mode = 2'h0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic awready, wready, bvalid, arready, rvalid, irq, pg_out, pg_oe, pg_pin;
    logic [1:0] bresp, rresp, r;
    logic [31:0] rdata, d;
    scr_pkg::scr_cmp_type cmp;
    scr_pkg::scr_drive_type drv;
    int n_errors = 0;
    int checked = 0;
    always #25 sys_clk = ~sys_clk;
    // Power good pin has a pull-up.
    assign pg_pin = pg_oe ? pg_out : 1'b1;
    scr_analog_model scr_analog_model_i (.sys_clk(sys_clk), .fb_ok(fb_ok), .oc_mode(oc_mode),
        .en(en), .hot(hot), .ov(ov), .drv(drv), .cmp(cmp));
    scr_fault_ctrl scr_fault_ctrl_i (.sys_clk(sys_clk), .rst(rst), .cmp_in(cmp),
        .drive_out(drv), .power_good_output_in(pg_pin), .power_good_output_out(pg_out),
        .power_good_output_oe(pg_oe), .irq(irq), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hF),
        .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
        .rdata(rdata), .rresp(rresp));
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            $display("FAIL %s expected %h seen %h", n, e, g);
            n_errors++;
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end
        while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            if (arready)
                arvalid <= 1'b0;
        end
        while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rd
    task automatic wait_drv(input scr_pkg::scr_drive_type m, input int lim, input string n);
        for (int k = 0; k < lim && (drv & m) === 5'h00; k++)
            @(posedge sys_clk);
        chk(n, 1, |(drv & m));
    endtask : wait_drv
    task automatic no_latch(input logic f, input logic [1:0] o, input string n);
        logic seen = 1'b0;
        fb_ok <= f;
        oc_mode <= o;
        repeat (400)
        begin
            @(posedge sys_clk);
            seen = seen | drv.ramp_discharge;
        end
        chk(n, 0, seen);
    endtask : no_latch
    task automatic t_regs;
        rd(`SCR_ADDR_MASK);
        chk("mask reset", {27'h0, `SCR_MASK_RESET}, d);
        wr(`SCR_ADDR_MASK, 32'h1F);
        rd(`SCR_ADDR_MASK);
        chk("mask rw", 32'h1F, d);
        wr(`SCR_ADDR_MASK, 32'h00);
        wr(`SCR_ADDR_STATUS, 32'h1F);
        chk("status write resp", `SCR_RESP_SLVERR, r);
        rd(4'h2);
        chk("unmapped resp", `SCR_RESP_SLVERR, r);
        $display("t_regs done");
    endtask : t_regs
    task automatic t_start;
        wait_drv(SW, 800, "first start");
        chk("amp released", 0, drv.error_amp_pulldown);
        rd(`SCR_ADDR_STATE);
        chk("state run", 4, d[2:0]);
        chk("power good", 1, pg_pin);
        chk("irq masked", 0, irq);
        $display("t_start done");
    endtask : t_start
    task automatic t_oc;
        no_latch(1'b0, 2'h2, "alternating oc latch");
        rd(`SCR_ADDR_STATE);
        chk("armed", 1, d[12]);
        chk("oc count low", 0, d[11:9]);
        $display("t_oc done");
    endtask : t_oc
    task automatic t_disarm;
        no_latch(1'b1, 2'h1, "disarmed oc latch");
        rd(`SCR_ADDR_STATE);
        chk("disarmed", 0, d[12]);
        chk("count cleared", 0, d[11:8]);
        oc_mode <= 2'h0;
        $display("t_disarm done");
    endtask : t_disarm
    task automatic t_retry;
        int n = 0;
        logic pw = 1'b1, pg_mid = 1'b1;
        wr(`SCR_ADDR_MASK, 32'h01);
        fb_ok <= 1'b0;
        repeat (40) @(posedge sys_clk);
        oc_mode <= 2'h1;
        for (int k = 0; k < 100 && !cmp.current_limit; k++)
            @(posedge sys_clk);
        for (int k = 0; k < 300 && !drv.ramp_discharge; k++)
        begin
            @(posedge sys_clk);
            n += int'(cmp.pwm_cycle && !pw);
            pw = cmp.pwm_cycle;
            if (n == 4)
                pg_mid = pg_pin;
        end
        chk("oc cycles to latch", 8, n);
        chk("heavy load power good", 0, pg_mid);
        chk("retry drive", EA | DIS, drv & (SW | EA | DIS | CHG));
        repeat (2) @(posedge sys_clk);
        chk("irq raised", 1, irq);
        rd(`SCR_ADDR_STATUS);
        chk("retry event", 1, d[0]);
        repeat (2) @(posedge sys_clk);
        chk("irq cleared", 0, irq);
        wait_drv(CHG, 300, "recharge");
        chk("sink off", 0, drv.ramp_discharge);
        wait_drv(DIS, 600, "second retry");
        wait_drv(CHG, 300, "recharge again");
        fb_ok <= 1'b1;
        oc_mode <= 2'h0;
        wait_drv(SW, 300, "restart");
        no_latch(1'b1, 2'h0, "retry after short removed");
        $display("t_retry done");
    endtask : t_retry
    task automatic t_faults;
        hot <= 1'b1;
        repeat (20) @(posedge sys_clk);
        chk("thermal drive", PD | EA, drv & (PD | EA | SW));
        chk("thermal power good", 0, pg_pin);
        hot <= 1'b0;
        wait_drv(SW, 800, "thermal recovery");
        ov <= 1'b1;
        repeat (20) @(posedge sys_clk);
        chk("ov drive", 0, drv & (PD | EA | SW | DIS));
        chk("ov power good", 0, pg_pin);
        ov <= 1'b0;
        wait_drv(SW, 40, "ov recovery");
        en <= 1'b0;
        repeat (224) @(posedge sys_clk);
        chk("enable low 28 cycles", 1, drv.switch_enable);
        repeat (80) @(posedge sys_clk);
        chk("en lost drive", EA, drv & (SW | EA));
        chk("en lost pg", 0, pg_pin);
        en <= 1'b1;
        wait_drv(SW, 800, "en recovery");
        wr(`SCR_ADDR_CTRL, 32'h1);
        chk("ctrl resp", `SCR_RESP_OKAY, r);
        repeat (4) @(posedge sys_clk);
        chk("force off drive", PD | EA, drv & (PD | EA | SW));
        wr(`SCR_ADDR_CTRL, 32'h0);
        wait_drv(SW, 800, "force off recovery");
        rd(`SCR_ADDR_STATUS);
        chk("fault events", 32'h0E, d & 32'h0E);
        $display("t_faults done");
    endtask : t_faults
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : stop_test
    initial
    begin
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        t_regs();
        t_start();
        t_oc();
        t_disarm();
        t_retry();
        t_faults();
        stop_test();
    end
    initial
    begin
        repeat (25000) @(posedge sys_clk);
        n_errors++;
        stop_test();
    end
endmodule : scr_fault_ctrl_test
